// ==== rf_level_sweep_sequencer.sv ====
// Two-path RF level sweep sequencer with AXI4-Lite register access.
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`include "level_sweep_consts.svh"
module rf_level_sweep_sequencer (
    input wire logic aclk, // System clock, 100 MHz.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic [7:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [7:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    input wire logic path_a_trigger_in, // Coaxial trigger for path A.
    input wire logic path_b_trigger_in, // Auxiliary trigger pin for path B.
    output logic [15:0] level_a, // Applied level of path A, signed.
    output logic [15:0] level_b, // Applied level of path B, signed.
    output logic level_sweep_on_a, // Level sweep active on path A.
    output logic level_sweep_on_b, // Level sweep active on path B.
    output logic [1:0] other_sweep_on_a, // Frequency and LF sweep, path A.
    output logic [1:0] other_sweep_on_b, // Frequency and LF sweep, path B.
    output logic list_on_a, // List mode on path A.
    output logic list_on_b, // List mode on path B.
    output logic range_error_a, // One-cycle pulse on clamped step, A.
    output logic range_error_b // One-cycle pulse on clamped step, B.
);
    // Per-path configuration, indexed 0 for A and 1 for B.
    logic enable [2];
    level_sweep_pkg::sweep_mode_t mode [2];
    logic shape_tri [2];
    logic [1:0] other_on [2];
    logic list_on [2];
    logic signed [15:0] start_lvl [2];
    logic signed [15:0] stop_lvl [2];
    logic signed [15:0] step_lvl [2];
    logic signed [15:0] knob_lvl [2];
    logic [31:0] dwell [2];
    // Per-path sweep state.
    logic signed [15:0] cur [2];
    logic running [2];
    logic dir_down [2];
    logic [31:0] dwell_cnt [2];
    logic err_flag [2];
    logic err_pulse [2];
    // Shared settings.
    logic trig_falling;
    logic high_power;
    logic hp_fitted;
    // Trigger synchronisers.
    logic [1:0] trig_meta;
    logic [1:0] trig_sync;
    logic [1:0] trig_prev;
    logic trig_pulse [2];
    // Bus state.
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic wr_hit [2];
    logic [7:0] wr_off;
    logic wr_global, wr_range;
    logic bad_wr;

    function automatic logic signed [15:0] sat_add(
        input logic signed [15:0] a,
        input logic signed [15:0] b
    );
        logic signed [16:0] s;
        s = 17'(a) + 17'(b);
        if (s > 17'sh07FFF)
            sat_add = 16'sh7FFF;
        else if (s < -17'sh08000)
            sat_add = -16'sh8000;
        else
            sat_add = s[15:0];
    endfunction

    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        merge = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                merge[i*8 +: 8] = data[i*8 +: 8];
    endfunction

    // Attenuator range limits shared by both paths.
    function automatic logic signed [15:0] range_lo(input logic hp);
        range_lo = (hp_fitted && hp) ? `HIGH_MIN : `NORMAL_MIN;
    endfunction

    function automatic logic signed [15:0] range_hi(input logic hp);
        range_hi = (hp_fitted && hp) ? `HIGH_MAX : `NORMAL_MAX;
    endfunction

    // Two flip-flops per trigger before the edge detector reads them.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            trig_meta <= 2'h0;
            trig_sync <= 2'h0;
            trig_prev <= 2'h0;
        end
        else
        begin
            trig_meta <= {path_b_trigger_in, path_a_trigger_in};
            trig_sync <= trig_meta;
            trig_prev <= trig_sync;
        end
    end

    always_comb
    begin
        for (int p = 0; p < 2; p++)
            trig_pulse[p] = trig_falling ? (trig_prev[p] && !trig_sync[p])
                : (!trig_prev[p] && trig_sync[p]);
    end

    // AXI4-Lite write channel: address and data are held until both arrive.
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= bad_wr ? `RESP_SLVERR : `RESP_OKAY;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_comb
    begin
        wr_off = aw_addr & ~`PATH_B_OFFSET;
        wr_hit[0] = do_write && aw_addr < `PATH_B_OFFSET;
        wr_hit[1] = do_write && aw_addr >= `PATH_B_OFFSET
            && aw_addr < `REG_GLOBAL;
        wr_global = do_write && aw_addr == `REG_GLOBAL;
        wr_range = do_write && aw_addr == `REG_RANGE;
        bad_wr = aw_addr > `REG_RANGE || aw_addr[1:0] != 2'h0;
    end

    // Shared trigger polarity and attenuator range.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            trig_falling <= 1'b0;
            high_power <= 1'b0;
            hp_fitted <= 1'b0;
        end
        else
        begin
            if (wr_global && w_strb[0])
                trig_falling <= w_data[0];
            if (wr_range && w_strb[0])
            begin
                high_power <= w_data[0];
                hp_fitted <= w_data[1];
            end
        end
    end

    // Each path is an independent copy; a write to one path never reaches
    // the other's state.
    for (genvar p = 0; p < 2; p++)
    begin : g_path
        logic wr_ctrl, wr_level, do_step, cycle_start, halt_entry;
        logic signed [15:0] inc, next_cur, lo, hi;
        logic at_end;
        level_sweep_pkg::sweep_mode_t new_mode;

        always_comb
        begin
            wr_ctrl = wr_hit[p] && wr_off == `REG_CTRL_A;
            wr_level = wr_hit[p] && wr_off == `REG_LEVEL_A;
            new_mode = level_sweep_pkg::sweep_mode_t'(
                w_data[`CTRL_MODE_LSB +: 3]);
            halt_entry = wr_ctrl && new_mode != mode[p]
                && new_mode != level_sweep_pkg::mode_auto;
            // Step size: knob increment in external step, else the dB step.
            inc = (mode[p] == level_sweep_pkg::mode_ext_step)
                ? knob_lvl[p] : step_lvl[p];
            if (dir_down[p])
                inc = -inc;
            next_cur = sat_add(cur[p], inc);
            at_end = dir_down[p] ? next_cur <= start_lvl[p]
                : next_cur >= stop_lvl[p];
            lo = range_lo(high_power);
            hi = range_hi(high_power);
            // Step sources per mode.
            case (mode[p])
                level_sweep_pkg::mode_auto,
                level_sweep_pkg::mode_ext_start_stop:
                    do_step = running[p]
                        && dwell_cnt[p] == 32'h00000000;
                level_sweep_pkg::mode_single,
                level_sweep_pkg::mode_ext_single:
                    do_step = running[p] && dwell_cnt[p] == 32'h00000000;
                level_sweep_pkg::mode_manual_step:
                    do_step = wr_level;
                level_sweep_pkg::mode_ext_step:
                    do_step = trig_pulse[p];
                default:
                    do_step = 1'b0;
            endcase
            do_step = do_step && enable[p];
            cycle_start = enable[p] && (
                (mode[p] == level_sweep_pkg::mode_single && wr_ctrl
                    && w_data[`CTRL_EXEC])
                || (mode[p] == level_sweep_pkg::mode_ext_single
                    && trig_pulse[p]));
        end

        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                enable[p] <= 1'b0;
                mode[p] <= level_sweep_pkg::mode_auto;
                shape_tri[p] <= 1'b0;
                other_on[p] <= 2'h0;
                list_on[p] <= 1'b0;
                start_lvl[p] <= 16'sh0000;
                stop_lvl[p] <= 16'sh0000;
                step_lvl[p] <= 16'sh0000;
                knob_lvl[p] <= 16'sh0000;
                dwell[p] <= `DWELL_RESET;
            end
            else if (wr_hit[p])
            begin
                case (wr_off)
                    `REG_CTRL_A:
                    begin
                        enable[p] <= w_data[`CTRL_ENABLE];
                        mode[p] <= new_mode;
                        shape_tri[p] <= w_data[`CTRL_SHAPE];
                        if (w_data[`CTRL_ENABLE])
                        begin
                            other_on[p] <= 2'h0;
                            list_on[p] <= 1'b0;
                        end
                        else
                        begin
                            other_on[p] <= w_data[`CTRL_OTHER_LSB +: 2];
                            list_on[p] <= w_data[`CTRL_OTHER_LSB + 2];
                        end
                    end
                    `REG_START_A: start_lvl[p] <= w_data[15:0];
                    `REG_STOP_A: stop_lvl[p] <= w_data[15:0];
                    `REG_STEP_A: step_lvl[p] <= w_data[15:0];
                    `REG_KNOB_A: knob_lvl[p] <= w_data[15:0];
                    `REG_DWELL_A: dwell[p] <= merge(dwell[p], w_data, w_strb);
                    default: ;
                endcase
            end
        end

        // Sweep position, direction and run state.
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                cur[p] <= 16'sh0000;
                running[p] <= 1'b0;
                dir_down[p] <= 1'b0;
                dwell_cnt[p] <= 32'h00000000;
                err_pulse[p] <= 1'b0;
                err_flag[p] <= 1'b0;
            end
            else
            begin
                err_pulse[p] <= 1'b0;
                // Clear first so that a clamp in the same cycle wins.
                if (wr_hit[p] && wr_off == `REG_STATUS_A
                    && w_data[`STATUS_ERR])
                    err_flag[p] <= 1'b0;
                if (wr_ctrl && w_data[`CTRL_RESET])
                begin
                    cur[p] <= start_lvl[p];
                    dir_down[p] <= 1'b0;
                    dwell_cnt[p] <= dwell[p] - 32'h1;
                end
                else if (halt_entry)
                begin
                    running[p] <= 1'b0;
                    dir_down[p] <= 1'b0;
                    if (new_mode == level_sweep_pkg::mode_ext_step)
                        cur[p] <= start_lvl[p];
                end
                else if (wr_ctrl && new_mode == level_sweep_pkg::mode_auto)
                    running[p] <= w_data[`CTRL_ENABLE];
                else if (cycle_start)
                begin
                    cur[p] <= start_lvl[p];
                    dir_down[p] <= 1'b0;
                    running[p] <= 1'b1;
                    dwell_cnt[p] <= dwell[p] - 32'h1;
                end
                else if (enable[p] && trig_pulse[p] && mode[p]
                    == level_sweep_pkg::mode_ext_start_stop)
                begin
                    running[p] <= !running[p];
                    dwell_cnt[p] <= dwell[p] - 32'h1;
                    // Restart from start only when resuming after a stop.
                    if (!running[p])
                    begin
                        cur[p] <= start_lvl[p];
                        dir_down[p] <= 1'b0;
                    end
                end
                else if (do_step)
                begin
                    dwell_cnt[p] <= dwell[p] - 32'h1;
                    if (at_end && !dir_down[p] && shape_tri[p])
                    begin
                        cur[p] <= stop_lvl[p];
                        dir_down[p] <= 1'b1;
                    end
                    else if (at_end)
                    begin
                        cur[p] <= start_lvl[p];
                        dir_down[p] <= 1'b0;
                        if (mode[p] == level_sweep_pkg::mode_single
                            || mode[p] == level_sweep_pkg::mode_ext_single)
                            running[p] <= 1'b0;
                    end
                    else if (next_cur < lo || next_cur > hi)
                    begin
                        cur[p] <= next_cur < lo ? lo : hi;
                        err_pulse[p] <= 1'b1;
                        err_flag[p] <= 1'b1;
                    end
                    else
                        cur[p] <= next_cur;
                end
                else if (running[p] && dwell_cnt[p] != 32'h00000000)
                    dwell_cnt[p] <= dwell_cnt[p] - 32'h1;
            end
        end
    end

    // AXI4-Lite read channel, answer one cycle after the address is taken.
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            if (s_axi_araddr < `REG_GLOBAL)
            begin
                case (s_axi_araddr & ~`PATH_B_OFFSET)
                    `REG_CTRL_A: s_axi_rdata <= {17'h0,
                        list_on[s_axi_araddr[5]],
                        other_on[s_axi_araddr[5]], 7'h0,
                        shape_tri[s_axi_araddr[5]],
                        mode[s_axi_araddr[5]], enable[s_axi_araddr[5]]};
                    `REG_START_A:
                        s_axi_rdata <= 32'(start_lvl[s_axi_araddr[5]]);
                    `REG_STOP_A: s_axi_rdata <= 32'(stop_lvl[s_axi_araddr[5]]);
                    `REG_STEP_A: s_axi_rdata <= 32'(step_lvl[s_axi_araddr[5]]);
                    `REG_KNOB_A: s_axi_rdata <= 32'(knob_lvl[s_axi_araddr[5]]);
                    `REG_DWELL_A: s_axi_rdata <= dwell[s_axi_araddr[5]];
                    `REG_LEVEL_A: s_axi_rdata <= 32'(cur[s_axi_araddr[5]]);
                    `REG_STATUS_A: s_axi_rdata <= {29'h0,
                        err_flag[s_axi_araddr[5]], dir_down[s_axi_araddr[5]],
                        running[s_axi_araddr[5]]};
                    default: s_axi_rresp <= `RESP_SLVERR;
                endcase
            end
            else if (s_axi_araddr == `REG_GLOBAL)
                s_axi_rdata <= {31'h0, trig_falling};
            else if (s_axi_araddr == `REG_RANGE)
                s_axi_rdata <= {30'h0, hp_fitted, high_power};
            else
                s_axi_rresp <= `RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    assign level_a = cur[0];
    assign level_b = cur[1];
    assign level_sweep_on_a = enable[0];
    assign level_sweep_on_b = enable[1];
    assign other_sweep_on_a = other_on[0];
    assign other_sweep_on_b = other_on[1];
    assign list_on_a = list_on[0];
    assign list_on_b = list_on[1];
    assign range_error_a = err_pulse[0];
    assign range_error_b = err_pulse[1];
endmodule // rf_level_sweep_sequencer

// ==== level_sweep_consts.svh ====
// Constants for the two-path level sweep sequencer.
// Summary of operation
// - Enabling level sweep on a path turns off other sweeps and list mode.
// - Each path keeps its own sweep state, independent of the other path.
// - Automatic mode repeats cycles and resumes from the present position.
// - Sweep reset loads the start level in every mode.
// - Single mode halts; each execute runs one cycle from start level.
// - Execute starts a sweep only in single mode; otherwise ignored.
// - Manual step mode halts, keeps level; each level write advances one step.
// - External single mode halts; each trigger edge runs one cycle from start.
// - External step mode halts at start; each trigger advances one knob step.
// - External start/stop triggers alternate run, freeze, restart from start.
// - Path A uses its coax trigger; path B uses the auxiliary pin.
// - One shared edge polarity setting applies to both trigger inputs.
// - Sawtooth runs start to stop, then jumps back to start.
// - Triangle runs start to stop and back, next cycle begins at start.
// - Step is one dB increment added each step; external step mode adds the knob increment instead.
// - Dwell time is the full step period.
// - A step to a level outside attenuator range raises error and clamps to nearest, unless it reaches the stop (or, descending, start) level.
// - Normal mode confines to electronic range, high power to high range only with hp_fitted set.
`ifndef LEVEL_SWEEP_CONSTS_SVH
`define LEVEL_SWEEP_CONSTS_SVH
`define REG_CTRL_A 8'h00
`define REG_START_A 8'h04
`define REG_STOP_A 8'h08
`define REG_STEP_A 8'h0C
`define REG_DWELL_A 8'h10
`define REG_KNOB_A 8'h14
`define REG_LEVEL_A 8'h18
`define REG_STATUS_A 8'h1C
`define PATH_B_OFFSET 8'h20
`define REG_GLOBAL 8'h40
`define REG_RANGE 8'h44
`define CTRL_ENABLE 0
`define CTRL_MODE_LSB 1
`define CTRL_SHAPE 4
`define CTRL_RESET 8
`define CTRL_EXEC 9
`define CTRL_OTHER_LSB 12
`define STATUS_RUNNING 0
`define STATUS_DIR_DOWN 1
`define STATUS_ERR 2
`define LEVEL_W 16
`define DWELL_RESET 32'h000F4240
`define NORMAL_MIN 16'h8300
`define NORMAL_MAX 16'h0A00
`define HIGH_MIN 16'h0A00
`define HIGH_MAX 16'h1A00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== level_sweep_pkg.sv ====
// Types for the level sweep sequencer.
package level_sweep_pkg;
    typedef enum logic [2:0] {
        mode_auto,
        mode_single,
        mode_manual_step,
        mode_ext_single,
        mode_ext_step,
        mode_ext_start_stop
    } sweep_mode_t;
endpackage

// ==== level_sweep_checker_sva.sv ====
// Bus handshake and path exclusion checks for the level sweep sequencer.
module level_sweep_checker (
    input wire logic aclk, // Clock.
    input wire logic aresetn, // Reset.
    input wire logic s_axi_awvalid, // Write address valid.
    input wire logic s_axi_awready, // Write address ready.
    input wire logic s_axi_wvalid, // Write data valid.
    input wire logic s_axi_wready, // Write data ready.
    input wire logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic s_axi_arvalid, // Read address valid.
    input wire logic s_axi_arready, // Read address ready.
    input wire logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    input wire logic level_sweep_on_a, // Sweep on, path A.
    input wire logic level_sweep_on_b, // Sweep on, path B.
    input wire logic [1:0] other_sweep_on_a, // Other sweeps, A.
    input wire logic [1:0] other_sweep_on_b, // Other sweeps, B.
    input wire logic list_on_a, // List mode, A.
    input wire logic list_on_b, // List mode, B.
    input wire logic range_error_a, // Clamp pulse, A.
    input wire logic range_error_b // Clamp pulse, B.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    write_resp_a: assert property ((s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready) |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid) else $error("write response dropped");
    read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read response missing");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid) else $error("read response dropped");
    write_block_a: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write taken early");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken early");
    path_a_excl_a: assert property (level_sweep_on_a |->
        other_sweep_on_a == 2'h0 && !list_on_a) else $error("A not alone");
    path_b_excl_a: assert property (level_sweep_on_b |->
        other_sweep_on_b == 2'h0 && !list_on_b) else $error("B not alone");
    error_pulse_a: assert property (range_error_a |->
        $past(level_sweep_on_a)) else $error("A error while off");
    error_b_pulse_a: assert property (range_error_b |->
        $past(level_sweep_on_b)) else $error("B error while off");
endmodule // level_sweep_checker

bind rf_level_sweep_sequencer level_sweep_checker chk_i (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .level_sweep_on_a, .level_sweep_on_b,
    .other_sweep_on_a, .other_sweep_on_b, .list_on_a, .list_on_b,
    .range_error_a, .range_error_b);

// ==== trig_source.sv ====
// Model of the external trigger source feeding both path trigger inputs.
module trig_source (
    input wire logic aclk, // Clock.
    output logic path_a_trigger_in, // Trigger to path A.
    output logic path_b_trigger_in // Trigger to path B.
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        path_a_trigger_in = 1'b0;
        path_b_trigger_in = 1'b0;
    end
    // A wide pulse proves one edge yields one step, not one per cycle.
    task automatic pulse(input logic sel);
        @(posedge aclk);
        if (sel)
            path_b_trigger_in <= 1'b1;
        else
            path_a_trigger_in <= 1'b1;
        repeat (4) @(posedge aclk);
        path_a_trigger_in <= 1'b0;
        path_b_trigger_in <= 1'b0;
        repeat (6) @(posedge aclk);
    endtask
endmodule // trig_source

// ==== tb_rf_level_sweep_sequencer.sv ====
// Self-checking bench for the level sweep sequencer.
module tb_rf_level_sweep_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, trig_a, trig_b;
    logic [1:0] bresp, rresp, other_a, wresp;
    logic [31:0] rdata, got;
    logic [15:0] level_a, level_b;
    logic on_b, list_a;
    int miscompares = 0;
    int n_compared = 0;
    logic [7:0] row_addr [6] = '{8'h04, 8'h08, 8'h0C, 8'h14, 8'h24, 8'h48};
    logic [31:0] row_data [6] = '{32'h100, 32'h200, 32'h10, 32'h8,
        32'h300, 32'h5};
    logic [31:0] row_exp [6] = '{32'h100, 32'h200, 32'h10, 32'h8,
        32'h300, 32'h0};
    logic [1:0] row_resp [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
    always #5 aclk = ~aclk;
    trig_source src_i (.aclk(aclk), .path_a_trigger_in(trig_a),
        .path_b_trigger_in(trig_b));
    rf_level_sweep_sequencer rf_level_sweep_sequencer_i (.aclk(aclk),
        .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .path_a_trigger_in(trig_a), .path_b_trigger_in(trig_b),
        .level_a(level_a), .level_b(level_b), .level_sweep_on_a(),
        .level_sweep_on_b(on_b), .other_sweep_on_a(other_a),
        .other_sweep_on_b(), .list_on_a(list_a), .list_on_b(),
        .range_error_a(), .range_error_b());
    task automatic finish_test;
        if (miscompares == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
            miscompares++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit done = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++)
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
                done = 1;
        end
        wresp = bresp;
        bready <= 1'b0;
        if (!done)
        begin
            miscompares++;
            finish_test;
        end
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a);
        bit done = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++)
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
                done = 1;
        end
        got = rdata;
        rready <= 1'b0;
        if (!done)
        begin
            miscompares++;
            finish_test;
        end
        @(posedge aclk);
    endtask
    initial
    begin
        repeat (5) @(posedge aclk);
        chk(level_a, 32'h0);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 6; i++)
        begin
            wr(row_addr[i], row_data[i]);
            rd(row_addr[i]);
            chk(wresp, row_resp[i]);
            chk(got, row_exp[i]);
            chk(rresp, row_resp[i]);
        end
        wr(8'h00, 32'h7000);
        chk(other_a, 32'h3);
        chk(list_a, 32'h1);
        wr(8'h00, 32'h0105);
        chk(other_a, 32'h0);
        chk(list_a, 32'h0);
        chk(level_a, 32'h100);
        chk({on_b, level_b}, 32'h0);
        wr(8'h18, 32'h150);
        wr(8'h18, 32'h150);
        chk(level_a, 32'h120);
        wr(8'h00, 32'h0205);
        chk(level_a, 32'h120);
        wr(8'h00, 32'h0109);
        chk(level_a, 32'h100);
        src_i.pulse(1'b0);
        chk(level_a, 32'h108);
        src_i.pulse(1'b1);
        chk(level_a, 32'h108);
        src_i.pulse(1'b0);
        chk(level_a, 32'h110);
        wr(8'h40, 32'h1);
        src_i.pulse(1'b0);
        chk(level_a, 32'h118);
        wr(8'h08, 32'h7000);
        wr(8'h14, 32'h1000);
        src_i.pulse(1'b0);
        chk(level_a, 32'h0A00);
        rd(8'h1C);
        chk(got, 32'h4);
        wr(8'h44, 32'h3);
        src_i.pulse(1'b0);
        chk(level_a, 32'h1A00);
        finish_test;
    end
endmodule // tb_rf_level_sweep_sequencer
